// file: hdl/tla_top.sv
`timescale 1ns/100ps
// How it works
// - after reset, pin resistor classes pick default critical limit, 77 to 125.
// - alert and critical pins are open drain, pulled low only when active.
// - each pin drives only when its enable bit is set.
// - fault queue on: three out-of-limit results in a row; off: one.
// - fault queue acts on remote only and is enabled after reset.
// - remote filter averages four samples at level one, eight at level two.
// - filtered remote value is stored and used for all remote comparisons.
// - filter off at reset; level zero clears history; works in all modes.
// - one-shot write starts one conversion in shutdown, ignored when continuous.
// - mode bit zero is interrupt mode, one is comparator mode.
// - alert asserts after a conversion above high or below low limit.
// - interrupt mode status read with a flag set sets alert suppress.
// - local and remote high flags set from their own result and limit.
// - remote low flag sets when remote result is below low limit.
// - interrupt mode status read clears flags; later conversions set again.
// - comparator mode releases alert when result back within limits.
// - comparator mode clears high and low flags when back within limits.
// - critical asserts above limit, releases below limit minus hysteresis.
// - suppress never masks critical; critical flags per channel, set again each conversion while critical.
// - comparator mode: critical flag clears only below hysteresis; no suppress.
// - shutdown aborts conversion, drops result, keeps flags and pins.
// - continuous mode converts back to back, busy high while converting.
// - local values are signed eight bit whole degrees.
// - remote values are signed eleven bit eighths, left justified in sixteen.
module tla_top #(
    parameter logic [1:0] FQ_LEN = tla_pkg::FQ_LEN
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // pullup resistor classes from the pin detector
    input  wire logic [2:0]  alert_res_cls,
    input  wire logic [2:0]  crit_res_cls,
    // open drain pins
    input  wire logic        alert_n_in,
    output logic             alert_n_out,
    output logic             alert_n_oe,
    input  wire logic        crit_n_in,
    output logic             crit_n_out,
    output logic             crit_n_oe,
    // converter
    output logic             adc_start,
    output logic             adc_abort,
    input  wire logic        adc_done,
    input  wire logic [7:0]  adc_local,
    input  wire logic [10:0] adc_remote,
    // configuration levels
    input  wire logic        shutdown,
    input  wire logic        comp_mode,
    input  wire logic        alert_en,
    input  wire logic        crit_en,
    input  wire logic [7:0]  hi_lim_local,
    input  wire logic [10:0] hi_lim_remote,
    input  wire logic [10:0] lo_lim_remote,
    input  wire logic [7:0]  crit_hyst,
    // write strobes
    input  wire logic        oneshot_wr,
    input  wire logic        supp_clr_wr,
    input  wire logic        fq_wr,
    input  wire logic        fq_wdata,
    input  wire logic        filt_wr,
    input  wire logic [1:0]  filt_wdata,
    input  wire logic        crit_wr_local,
    input  wire logic        crit_wr_remote,
    input  wire logic [7:0]  crit_wdata,
    // status and results
    input  wire logic        status_rd,
    output logic [5:0]       status,
    output logic             alert_suppress_bit,
    output logic [7:0]       temp_local,
    output logic [15:0]      temp_remote,
    output logic [7:0]       crit_lim_local,
    output logic [7:0]       crit_lim_remote,
    output logic             fq_en,
    output logic [1:0]       filt_level,
    output logic [1:0]       pin_low
);
    logic [1:0]              rst_s_q;
    logic                    rst_sn;
    logic [7:0]              sync_out;
    tla_pkg::tla_seq_type    seq_q;
    tla_pkg::tla_seq_type    seq_d;
    logic                    os_q;
    logic                    os_d;
    logic                    eoc;
    logic                    busy;
    logic [10:0]             r_filt;
    logic                    l_hi;
    logic                    l_cr;
    logic                    l_rel;
    logic                    r_hi;
    logic                    r_lo;
    logic                    r_cr;
    logic                    r_rel;
    logic [2:0]              q_hit;
    logic [1:0]              fq_cnt_q [3];
    logic [1:0]              fq_cnt_d [3];
    logic signed [9:0]       l_thr;
    logic signed [12:0]      r_thr;
    logic [4:0]              flag_q;
    logic [4:0]              flag_d;
    logic [4:0]              f_set;
    logic [4:0]              f_clr;
    logic                    cra_l_q;
    logic                    cra_l_d;
    logic                    cra_r_q;
    logic                    cra_r_d;
    logic                    supp_q;
    logic                    supp_d;
    logic                    alert_q;
    logic                    alert_d;
    logic                    crit_q;
    logic                    crit_d;
    logic                    fq_q;
    logic                    fq_d;
    logic [1:0]              filt_q;
    logic [1:0]              filt_d;
    logic [7:0]              crl_q;
    logic [7:0]              crl_d;
    logic [7:0]              crr_q;
    logic [7:0]              crr_d;
    logic                    dec_q;
    logic                    dec_d;
    logic [1:0]              dec_cnt_q;
    logic [1:0]              dec_cnt_d;
    logic [7:0]              tl_q;
    logic [7:0]              tl_d;
    logic [10:0]             tr_q;
    logic [10:0]             tr_d;

    function automatic logic [1:0] fq_next(input logic hit, input logic [1:0] c);
        return hit ? ((c == 2'h3) ? c : c + 2'h1) : 2'h0;
    endfunction

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s_q <= 2'h0;
        end else begin
            rst_s_q <= {rst_s_q[0], 1'b1};
        end
    end
    assign rst_sn = rst_s_q[1];

    tla_sync #(.W(8)) u_sync (
        .clk   (mclk),
        .rst_n (rst_sn),
        .din   ({crit_res_cls, alert_res_cls, crit_n_in, alert_n_in}),
        .dout  (sync_out)
    );

    tla_filter #(.W(tla_pkg::REM_W), .DEPTH(tla_pkg::FILT_DEPTH)) u_filt (
        .clk       (mclk),
        .rst_n     (rst_sn),
        .smp_valid (eoc),
        .smp       (adc_remote),
        .level     (filt_q),
        .clear     (filt_q == tla_pkg::FILT_OFF),
        .avg       (r_filt)
    );

    // conversion sequencer
    always_comb begin
        seq_d = seq_q;
        os_d = os_q;
        adc_start = 1'b0;
        adc_abort = 1'b0;
        eoc = 1'b0;
        case (seq_q)
            tla_pkg::SEQ_IDLE: begin
                if (!shutdown || oneshot_wr) begin
                    seq_d = tla_pkg::SEQ_CONV;
                    os_d = shutdown;
                    adc_start = 1'b1;
                end
            end
            tla_pkg::SEQ_CONV: begin
                if (shutdown && !os_q) begin
                    adc_abort = 1'b1;
                    seq_d = tla_pkg::SEQ_IDLE;
                end else if (adc_done) begin
                    eoc = 1'b1;
                    seq_d = tla_pkg::SEQ_IDLE;
                end
            end
            default: begin
                seq_d = tla_pkg::SEQ_IDLE;
            end
        endcase
    end
    assign busy = (seq_q == tla_pkg::SEQ_CONV);

    always_comb begin
        l_thr = $signed({{2{crl_q[7]}}, crl_q}) - $signed({2'b00, crit_hyst});
        r_thr = $signed({{2{crr_q[7]}}, crr_q, 3'b000}) - $signed({2'b00, crit_hyst, 3'b000});
        l_hi = $signed(adc_local) > $signed(hi_lim_local);
        l_cr = $signed(adc_local) > $signed(crl_q);
        l_rel = $signed({{2{adc_local[7]}}, adc_local}) < l_thr;
        r_hi = $signed(r_filt) > $signed(hi_lim_remote);
        r_lo = $signed(r_filt) < $signed(lo_lim_remote);
        r_cr = $signed(r_filt) > $signed({crr_q, 3'b000});
        r_rel = $signed({{2{r_filt[10]}}, r_filt}) < r_thr;
    end

    always_comb begin
        fq_cnt_d = fq_cnt_q;
        if (eoc) begin
            fq_cnt_d[0] = fq_next(r_hi, fq_cnt_q[0]);
            fq_cnt_d[1] = fq_next(r_lo, fq_cnt_q[1]);
            fq_cnt_d[2] = fq_next(r_cr, fq_cnt_q[2]);
        end
        q_hit[0] = r_hi && (!fq_q || fq_cnt_q[0] >= FQ_LEN - 2'h1);
        q_hit[1] = r_lo && (!fq_q || fq_cnt_q[1] >= FQ_LEN - 2'h1);
        q_hit[2] = r_cr && (!fq_q || fq_cnt_q[2] >= FQ_LEN - 2'h1);
    end

    // critical state with hysteresis, flags, suppress, pins
    always_comb begin
        cra_l_d = cra_l_q;
        cra_r_d = cra_r_q;
        if (eoc && l_cr) begin
            cra_l_d = 1'b1;
        end else if (eoc && l_rel) begin
            cra_l_d = 1'b0;
        end
        if (eoc && q_hit[2]) begin
            cra_r_d = 1'b1;
        end else if (eoc && r_rel) begin
            cra_r_d = 1'b0;
        end
        f_set = '0;
        f_set[tla_pkg::F_HI_L] = eoc && l_hi;
        f_set[tla_pkg::F_HI_R] = eoc && q_hit[0];
        f_set[tla_pkg::F_LO_R] = eoc && q_hit[1];
        f_set[tla_pkg::F_CR_L] = eoc && cra_l_d;
        f_set[tla_pkg::F_CR_R] = eoc && cra_r_d;
        // comparator clears at end of conversion
        f_clr = '0;
        f_clr[tla_pkg::F_HI_L] = !l_hi;
        f_clr[tla_pkg::F_HI_R] = !r_hi;
        f_clr[tla_pkg::F_LO_R] = !r_lo;
        f_clr[tla_pkg::F_CR_L] = !cra_l_d;
        f_clr[tla_pkg::F_CR_R] = !cra_r_d;
        f_clr = f_clr & {5{eoc && comp_mode}};
        // read clears; set wins over any clear
        for (int i = 0; i < tla_pkg::NFLAG; i++) begin
            if (f_set[i]) begin
                flag_d[i] = 1'b1;
            end else if (f_clr[i] || (status_rd && !comp_mode)) begin
                flag_d[i] = 1'b0;
            end else begin
                flag_d[i] = flag_q[i];
            end
        end
        // suppress on read in interrupt mode
        if (status_rd && !comp_mode && (|flag_q)) begin
            supp_d = 1'b1;
        end else if (supp_clr_wr) begin
            supp_d = 1'b0;
        end else begin
            supp_d = supp_q;
        end
        alert_d = alert_en && (|flag_q[2:0]) && (comp_mode || !supp_q);
        crit_d = crit_en && (cra_l_q || cra_r_q);
    end

    // configuration, limits, results
    always_comb begin
        fq_d = fq_wr ? fq_wdata : fq_q;
        filt_d = filt_wr ? filt_wdata : filt_q;
        crl_d = crl_q;
        crr_d = crr_q;
        dec_d = dec_q;
        dec_cnt_d = dec_cnt_q;
        if (!dec_q) begin
            dec_cnt_d = dec_cnt_q + 2'h1;
            if (dec_cnt_q == 2'(tla_pkg::DEC_WAIT)) begin
                dec_d = 1'b1;
                crl_d = tla_pkg::crit_default(sync_out[7:5], sync_out[4:2]);
                crr_d = tla_pkg::crit_default(sync_out[7:5], sync_out[4:2]);
            end
        end else begin
            if (crit_wr_local) begin
                crl_d = crit_wdata;
            end
            if (crit_wr_remote) begin
                crr_d = crit_wdata;
            end
        end
        tl_d = eoc ? adc_local : tl_q;
        tr_d = eoc ? r_filt : tr_q;
    end

    always_ff @(posedge mclk or negedge rst_sn) begin
        if (!rst_sn) begin
            seq_q <= tla_pkg::SEQ_IDLE;
            os_q <= 1'b0;
            fq_cnt_q <= '{2'h0, 2'h0, 2'h0};
            cra_l_q <= 1'b0;
            cra_r_q <= 1'b0;
            flag_q <= '0;
            supp_q <= 1'b0;
            alert_q <= 1'b0;
            crit_q <= 1'b0;
            fq_q <= tla_pkg::FQ_RST;
            filt_q <= tla_pkg::FILT_RST;
            crl_q <= tla_pkg::CRIT_BASE;
            crr_q <= tla_pkg::CRIT_BASE;
            dec_q <= 1'b0;
            dec_cnt_q <= 2'h0;
            tl_q <= 8'h00;
            tr_q <= 11'h000;
        end else begin
            seq_q <= seq_d;
            os_q <= os_d;
            fq_cnt_q <= fq_cnt_d;
            cra_l_q <= cra_l_d;
            cra_r_q <= cra_r_d;
            flag_q <= flag_d;
            supp_q <= supp_d;
            alert_q <= alert_d;
            crit_q <= crit_d;
            fq_q <= fq_d;
            filt_q <= filt_d;
            crl_q <= crl_d;
            crr_q <= crr_d;
            dec_q <= dec_d;
            dec_cnt_q <= dec_cnt_d;
            tl_q <= tl_d;
            tr_q <= tr_d;
        end
    end

    assign alert_n_out = 1'b0;
    assign alert_n_oe = alert_q;
    assign crit_n_out = 1'b0;
    assign crit_n_oe = crit_q;
    assign status = {flag_q, busy};
    assign alert_suppress_bit = supp_q;
    assign temp_local = tl_q;
    assign temp_remote = {tr_q, 5'h00};
    assign crit_lim_local = crl_q;
    assign crit_lim_remote = crr_q;
    assign fq_en = fq_q;
    assign filt_level = filt_q;
    assign pin_low = ~sync_out[1:0];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_sn);

    sequence s_abort_req;
        seq_q == tla_pkg::SEQ_CONV && shutdown && !os_q;
    endsequence
    sequence s_abort_done;
        adc_abort && !eoc ##1 !status[tla_pkg::ST_BUSY];
    endsequence
    property p_abort;
        s_abort_req |-> s_abort_done;
    endproperty
    a_abort: assert property (p_abort) else $error("shutdown did not abort");

    property p_busy;
        adc_start |=> status[tla_pkg::ST_BUSY] && !adc_start;
    endproperty
    a_busy: assert property (p_busy) else $error("busy not set on start");

    property p_no_start;
        shutdown && !oneshot_wr |-> !adc_start;
    endproperty
    a_no_start: assert property (p_no_start) else $error("start in shutdown");

    property p_alert_en;
        !alert_en |=> !alert_n_oe;
    endproperty
    a_alert_en: assert property (p_alert_en) else $error("alert driven while disabled");

    property p_crit_nomask;
        crit_en && (cra_l_q || cra_r_q) |=> crit_n_oe;
    endproperty
    a_crit_nomask: assert property (p_crit_nomask) else $error("critical pin masked");

    property p_supp_set;
        status_rd && !comp_mode && (|status[5:1]) |=> alert_suppress_bit;
    endproperty
    a_supp_set: assert property (p_supp_set) else $error("suppress not set on read");

    property p_supp_cmp;
        status_rd && comp_mode && !alert_suppress_bit |=> !alert_suppress_bit;
    endproperty
    a_supp_cmp: assert property (p_supp_cmp) else $error("suppress set in comparator mode");

    property p_rd_clr;
        status_rd && !comp_mode && !eoc |=> !status[1 + tla_pkg::F_HI_L];
    endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("read did not clear flag");

    property p_hi_set;
        eoc && l_hi |=> status[1 + tla_pkg::F_HI_L];
    endproperty
    a_hi_set: assert property (p_hi_set) else $error("local high flag not set");

    property p_cmp_clr;
        eoc && comp_mode && !l_hi |=> !status[1 + tla_pkg::F_HI_L];
    endproperty
    a_cmp_clr: assert property (p_cmp_clr) else $error("comparator clear missed");

    property p_fq;
        fq_q && eoc && r_hi && fq_cnt_q[0] == 2'h0 && !status[1 + tla_pkg::F_HI_R]
            |=> !status[1 + tla_pkg::F_HI_R];
    endproperty
    a_fq: assert property (p_fq) else $error("fault queue bypassed");

    property p_filt_store;
        eoc |=> temp_remote == {$past(r_filt), 5'h00};
    endproperty
    a_filt_store: assert property (p_filt_store) else $error("remote result not filtered value");

    property p_crit_set;
        eoc && l_cr |=> cra_l_q ##1 (crit_n_oe == crit_en);
    endproperty
    a_crit_set: assert property (p_crit_set) else $error("critical not asserted");
endmodule

// file: hdl/tla_pkg.sv
package tla_pkg;

    // value widths
    localparam int LOC_W = 8;
    localparam int REM_W = 11;
    localparam int REM_FRAC = 3;
    localparam int REM_PAD = 5;
    localparam int CLS_W = 3;

    // default critical limit grid
    localparam logic [7:0] CRIT_BASE = 8'h4d;
    localparam logic [7:0] CRIT_STEP_CRIT = 8'h0a;
    localparam logic [7:0] CRIT_STEP_ALERT = 8'h02;
    localparam logic [2:0] CLASS_MAX = 3'h4;

    // fault queue and filter
    localparam logic [1:0] FQ_LEN = 2'h3;
    localparam logic FQ_RST = 1'b1;
    localparam logic [1:0] FILT_OFF = 2'h0;
    localparam logic [1:0] FILT_L1 = 2'h1;
    localparam logic [1:0] FILT_L2 = 2'h2;
    localparam logic [1:0] FILT_RST = 2'h0;
    localparam int FILT_DEPTH = 8;

    // status flag positions, busy sits below them
    localparam int NFLAG = 5;
    localparam int F_HI_L = 0;
    localparam int F_HI_R = 1;
    localparam int F_LO_R = 2;
    localparam int F_CR_L = 3;
    localparam int F_CR_R = 4;
    localparam int ST_BUSY = 0;
    localparam int DEC_WAIT = 3;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_CONV = 2'b10
    } tla_seq_type;

    function automatic logic [7:0] crit_default(input logic [2:0] cc, input logic [2:0] ac);
        logic [2:0] c;
        logic [2:0] a;
        c = (cc > CLASS_MAX) ? CLASS_MAX : cc;
        a = (ac > CLASS_MAX) ? CLASS_MAX : ac;
        return CRIT_BASE + {5'h00, c} * CRIT_STEP_CRIT + {5'h00, a} * CRIT_STEP_ALERT;
    endfunction

endpackage

// file: hdl/tla_sync.sv
`timescale 1ns/100ps
module tla_sync #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // levels
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
        end
    end

    assign dout = s2_q;
endmodule

// file: hdl/tla_filter.sv
`timescale 1ns/100ps
module tla_filter #(
    parameter int W = 11,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // samples
    input  wire logic         smp_valid,
    input  wire logic [W-1:0] smp,
    input  wire logic [1:0]   level,
    input  wire logic         clear,
    output logic      [W-1:0] avg
);
    logic [W-1:0] hist_q [DEPTH-1];
    logic [W-1:0] hist_d [DEPTH-1];
    logic         empty_q;
    logic         empty_d;
    logic signed [W+2:0] sum4;
    logic signed [W+2:0] sum8;
    logic signed [W+2:0] h;

    // empty history takes the sample itself so the first output is not dragged toward zero
    always_comb begin
        h = '0;
        sum4 = (W+3)'($signed(smp));
        sum8 = (W+3)'($signed(smp));
        for (int i = 0; i < DEPTH - 1; i++) begin
            h = empty_q ? (W+3)'($signed(smp)) : (W+3)'($signed(hist_q[i]));
            if (i < 3) begin
                sum4 = sum4 + h;
            end
            sum8 = sum8 + h;
        end
        if (level == tla_pkg::FILT_L2) begin
            avg = W'(sum8 >>> 3);
        end else if (level == tla_pkg::FILT_L1) begin
            avg = W'(sum4 >>> 2);
        end else begin
            avg = smp;
        end
    end

    always_comb begin
        hist_d = hist_q;
        empty_d = empty_q;
        if (clear) begin
            empty_d = 1'b1;
        end else if (smp_valid) begin
            empty_d = 1'b0;
            for (int i = DEPTH - 2; i > 0; i--) begin
                hist_d[i] = empty_q ? smp : hist_q[i-1];
            end
            hist_d[0] = smp;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            empty_q <= 1'b1;
            for (int i = 0; i < DEPTH - 1; i++) begin
                hist_q[i] <= '0;
            end
        end else begin
            empty_q <= empty_d;
            hist_q <= hist_d;
        end
    end
endmodule

// file: verification/tla_adc_model.sv
`timescale 1ns/100ps
// converter stand-in: answers each start after LAT cycles, abort drops it
module tla_adc_model #(
    parameter int LAT = 4
) (
    input  wire logic        mclk,
    input  wire logic        start,
    input  wire logic        abort,
    input  wire logic [7:0]  loc,
    input  wire logic [10:0] rem,
    output logic             done,
    output logic [7:0]       loc_bus,
    output logic [10:0]      rem_bus
);
    int   cnt    = 0;
    logic done_q = 1'b0;
    // data only valid with done; inverted otherwise so stale sampling shows
    assign done    = done_q;
    assign loc_bus = done_q ? loc : ~loc;
    assign rem_bus = done_q ? rem : ~rem;
    always @(posedge mclk) begin
        done_q <= (cnt == 1);
        if (abort)
            cnt <= 0;
        else if (start)
            cnt <= LAT;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
endmodule

// file: verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic mclk = 0, rst_n = 0, shutdown = 1, comp_mode = 0, alert_en = 1, crit_en = 1;
    logic oneshot_wr = 0, supp_clr_wr = 0, fq_wr = 0, fq_wdata = 0, status_rd = 0, crit_wr_local = 0, filt_wr = 0;
    logic [1:0] filt_wdata = 2'h0;
    logic [2:0] alert_res_cls = 3'h1, crit_res_cls = 3'h2;
    logic [7:0] hi_lim_local = 8'h32, crit_hyst = 8'h05, crit_wdata = 8'h3c, lv = 0;
    logic [10:0] hi_lim_remote = 11'h190, lo_lim_remote = 11'h050, rv = 0;
    logic alert_n_out, alert_n_oe, crit_n_out, crit_n_oe, adc_start, adc_abort, adc_done, alert_suppress_bit, fq_en;
    logic [5:0] status;
    logic [7:0] temp_local, crit_lim_local, crit_lim_remote, adc_local;
    logic [15:0] temp_remote;
    logic [10:0] adc_remote;
    logic [1:0] filt_level, pin_low;
    wire alert_n_in = alert_n_oe ? alert_n_out : 1'b1;
    wire crit_n_in = crit_n_oe ? crit_n_out : 1'b1;
    int errors = 0, num_checks = 0;
    tla_top dut_u (.mclk, .rst_n, .alert_res_cls, .crit_res_cls, .alert_n_in, .alert_n_out, .alert_n_oe,
        .crit_n_in, .crit_n_out, .crit_n_oe, .adc_start, .adc_abort, .adc_done, .adc_local, .adc_remote,
        .shutdown, .comp_mode, .alert_en, .crit_en, .hi_lim_local, .hi_lim_remote, .lo_lim_remote,
        .crit_hyst, .oneshot_wr, .supp_clr_wr, .fq_wr, .fq_wdata, .filt_wr, .filt_wdata,
        .crit_wr_local, .crit_wr_remote(1'b0), .crit_wdata, .status_rd, .status, .alert_suppress_bit,
        .temp_local, .temp_remote, .crit_lim_local, .crit_lim_remote, .fq_en, .filt_level, .pin_low);
    tla_adc_model adc_u (.mclk, .start(adc_start), .abort(adc_abort), .loc(lv), .rem(rv), .done(adc_done),
        .loc_bus(adc_local), .rem_bus(adc_remote));
    initial begin
        forever #10 mclk = ~mclk;
    end
    task finish_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    // one-shot conversion, returns once pins have settled
    task conv(input logic [7:0] l, input logic [10:0] r);
        @(posedge mclk);
        lv <= l;
        rv <= r;
        oneshot_wr <= 1'b1; // host stays idle until done
        @(posedge mclk);
        oneshot_wr <= 1'b0;
        for (int i = 0; i < 20; i++) begin
            @(posedge mclk);
            #1;
            if (adc_done) break;
        end
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task strobe(input int which);
        @(posedge mclk);
        if (which == 0) status_rd <= 1'b1;
        else supp_clr_wr <= 1'b1;
        @(posedge mclk);
        status_rd <= 1'b0;
        supp_clr_wr <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask
    initial begin
        repeat (5000) @(posedge mclk);
        errors++;
        finish_test;
    end
    task filt(input logic [1:0] lvl);
        @(posedge mclk);
        filt_wdata <= lvl;
        filt_wr <= 1'b1;
        @(posedge mclk);
        filt_wr <= 1'b0;
        #1;
    endtask
    // reset defaults and decoded critical limit
    task t_reset;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (12) @(posedge mclk);
        #1;
        chk(crit_lim_local, 8'h63);
        chk(crit_lim_remote, 8'h63);
        chk({fq_en, filt_level}, 3'h4);
        chk(alert_n_oe, 1'b0);
    endtask
    // interrupt mode: flags, read clear, suppress
    task t_interrupt;
        conv(8'h33, 11'h0c8);
        chk(status[5:1], 5'h01);
        chk(temp_local, 8'h33);
        chk(temp_remote, {11'h0c8, 5'h00});
        // pin readback needs the two synchroniser stages
        repeat (2) @(posedge mclk);
        #1;
        chk({alert_n_oe, alert_n_out, pin_low[0]}, 3'h5);
        strobe(0);
        chk({status[1], alert_suppress_bit, alert_n_oe}, 3'h2);
        conv(8'h33, 11'h0c8);
        chk({status[1], alert_n_oe}, 2'h2);
        strobe(1);
        chk(alert_n_oe, 1'b1);
        strobe(0);
        strobe(1);
    endtask
    task t_fault_queue;
        conv(8'h14, 11'h191);
        conv(8'h14, 11'h191);
        chk(status[2], 1'b0);
        conv(8'h14, 11'h191);
        chk(status[2], 1'b1);
        strobe(0);
        strobe(1);
        @(posedge mclk);
        fq_wr <= 1'b1;
        @(posedge mclk);
        fq_wr <= 1'b0;
        conv(8'h14, 11'h04f);
        chk({fq_en, status[3], alert_n_oe}, 3'h3);
    endtask
    task t_comparator;
        @(posedge mclk);
        comp_mode <= 1'b1;
        strobe(0);
        chk({status[3], alert_suppress_bit}, 2'h2);
        conv(8'h32, 11'h050);
        chk({status[3:1], alert_n_oe}, 4'h0);
    endtask
    task t_critical;
        @(posedge mclk);
        crit_wr_local <= 1'b1;
        @(posedge mclk);
        crit_wr_local <= 1'b0;
        #1;
        chk(crit_lim_local, 8'h3c);
        conv(8'h3d, 11'h0c8);
        chk({crit_n_oe, status[4]}, 2'h3);
        conv(8'h38, 11'h0c8);
        chk({crit_n_oe, status[4]}, 2'h3);
        conv(8'h36, 11'h0c8);
        chk({crit_n_oe, status[4], alert_n_oe}, 3'h1);
        // remote limit 99 degrees is 792 eighths, release below 752
        conv(8'h36, 11'h319);
        repeat (2) @(posedge mclk);
        #1;
        chk({crit_n_oe, crit_n_out, status[5], pin_low[1]}, 4'hb);
        conv(8'h36, 11'h2ef);
        chk({crit_n_oe, status[5]}, 2'h0);
    endtask
    task t_shutdown;
        @(posedge mclk);
        lv <= 8'h0a;
        shutdown <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk(status[0], 1'b1);
        @(posedge mclk);
        shutdown <= 1'b1;
        repeat (12) @(posedge mclk);
        #1;
        chk({status[0], temp_local, alert_n_oe}, {1'b0, 8'h36, 1'b1});
    endtask
    // empty history is filled with the first sample
    task t_filter;
        filt(2'h1);
        chk(filt_level, 2'h1);
        conv(8'h36, 11'h0c8);
        chk(temp_remote, {11'h0c8, 5'h00});
        conv(8'h36, 11'h0d0);
        chk(temp_remote, {11'h0ca, 5'h00});
        filt(2'h0);
        filt(2'h2);
        conv(8'h36, 11'h0c0);
        chk(temp_remote, {11'h0c0, 5'h00});
        conv(8'h36, 11'h0d0);
        chk(temp_remote, {11'h0c2, 5'h00});
        @(posedge mclk);
        alert_en <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk(alert_n_oe, 1'b0);
    endtask
    initial begin
        t_reset;
        t_interrupt;
        t_fault_queue;
        t_comparator;
        t_critical;
        t_shutdown;
        t_filter;
        finish_test;
    end
endmodule
